// >>> rh_status_pkg.sv
// Purpose: Shared constants and carriers for the root hub status block
// Assumes: 32-bit AHB-Lite register bus, 50 MHz hclk
// Notes:   Register index 14h maps to byte address 50h
package rh_status_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0]  RH_STATUS_READ_CODE  = 8'h14;
  localparam logic [7:0]  RH_STATUS_WRITE_CODE = 8'h94;
  localparam logic [11:0] RH_STATUS_ADDR   = 12'h050;
  localparam logic [11:0] PWR_CTRL_ADDR    = 12'h100;
  localparam logic [11:0] PORT_STATE_ADDR  = 12'h104;
  localparam logic [11:0] WAKE_CTRL_ADDR   = 12'h108;
  localparam logic [11:0] IRQ_STATUS_ADDR  = 12'h10c;
  localparam logic [11:0] IRQ_CLEAR_ADDR   = 12'h110;
  localparam logic [11:0] IRQ_ENABLE_ADDR  = 12'h114;
  localparam logic [31:0] RH_STATUS_RESET  = 32'h0000_0000;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CLR_WAKE_BIT   = 31;
  localparam int OC_CHANGE_BIT  = 17;
  localparam int SET_PWR_BIT    = 16;
  localparam int WAKE_EN_BIT    = 15;
  localparam int GLOBAL_OC_BIT  = 1;
  localparam int CLR_PWR_BIT    = 0;
  localparam int PER_PORT_SW_BIT = 0;
  localparam int PER_PORT_OC_BIT = 1;
  localparam int MASK_LSB       = 16;
  localparam int NUM_PORTS      = 2;
  localparam int IRQ_BITS       = 3;
  localparam int IRQ_OC_CHG     = 0;
  localparam int IRQ_RESUME     = 1;
  localparam int IRQ_PWR_CMD    = 2;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic        sel;
    logic        write;
    logic [11:0] addr;
  } ahb_req_s;

  typedef enum logic [2:0] {
    ST_RUNNING  = 3'b001,
    ST_SUSPEND  = 3'b010,
    ST_RESUMING = 3'b100
  } hub_state_e;

endpackage

// >>> port_power_cell.sv
// Purpose: One downstream port power state bit
// Assumes: Commands are single-cycle pulses from the status register
// Notes:   Mask applies only in per-port switching mode
`timescale 1ns/10ps
module port_power_cell (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Commands
  input  wire logic set_cmd,
  input  wire logic clr_cmd,
  input  wire logic per_port_mode,
  input  wire logic mask_bit,
  // State
  output logic      power_on
);
  logic affected;
  logic power_r;
  logic power_nxt;

  assign affected  = !per_port_mode || !mask_bit;
  assign power_nxt = (affected && set_cmd) ? 1'b1 :
                     (affected && clr_cmd) ? 1'b0 : power_r;
  assign power_on  = power_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_r <= 1'b0;
    end else begin
      power_r <= power_nxt;
    end
  end

endmodule

// >>> root_hub_status.sv
// Purpose: Root hub status register with AHB-Lite slave and interrupt
// Assumes: Overcurrent and connect-change inputs are asynchronous pins
// Notes:   Zero-wait-state slave; unmapped reads return zero
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/10ps
module root_hub_status
  import rh_status_pkg::*;
(
  // AHB-Lite slave
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Hub pins
  input  wire logic        overcurrent_pin,
  input  wire logic        connect_change_flag,
  // Hub outputs
  output logic [NUM_PORTS:1] port_power_state,
  output logic             resume_seen_interrupt,
  output logic             suspended_state,
  output logic             resuming_state,
  output logic             irq
);
  import rh_status_pkg::*;

  // ****************************************
  // Bus request capture
  // ****************************************
  ahb_req_s req_r;
  ahb_req_s req_nxt;
  logic     wr_rh;
  logic     wr_pwr;
  logic     wr_wake;
  logic     wr_clr;
  logic     wr_en;

  assign req_nxt.sel   = hsel && htrans[1] && hready;
  assign req_nxt.write = hwrite;
  assign req_nxt.addr  = haddr;

  assign wr_rh   = req_r.sel && req_r.write && (req_r.addr == RH_STATUS_ADDR);
  assign wr_pwr  = req_r.sel && req_r.write && (req_r.addr == PWR_CTRL_ADDR);
  assign wr_wake = req_r.sel && req_r.write && (req_r.addr == WAKE_CTRL_ADDR);
  assign wr_clr  = req_r.sel && req_r.write && (req_r.addr == IRQ_CLEAR_ADDR);
  assign wr_en   = req_r.sel && req_r.write && (req_r.addr == IRQ_ENABLE_ADDR);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_r <= '0;
    end else begin
      req_r <= req_nxt;
    end
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [1:0] oc_sync_r;
  logic [1:0] cc_sync_r;
  logic       cc_last_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      oc_sync_r <= 2'h0;
      cc_sync_r <= 2'h0;
      cc_last_r <= 1'b0;
    end else begin
      oc_sync_r <= {oc_sync_r[0], overcurrent_pin};
      cc_sync_r <= {cc_sync_r[0], connect_change_flag};
      cc_last_r <= cc_sync_r[1];
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  logic [2:0] port_power_mask_field_r;
  logic       per_port_switching_select_r;
  logic       per_port_oc_r;
  logic       suspend_req_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_power_mask_field_r     <= 3'h0;
      per_port_switching_select_r <= 1'b0;
      per_port_oc_r               <= 1'b0;
      suspend_req_r               <= 1'b0;
    end else begin
      if (wr_pwr) begin
        port_power_mask_field_r     <= {hwdata[MASK_LSB+2:MASK_LSB+1], 1'b0};
        per_port_switching_select_r <= hwdata[PER_PORT_SW_BIT];
        per_port_oc_r               <= hwdata[PER_PORT_OC_BIT];
      end
      suspend_req_r <= wr_wake && hwdata[0];
    end
  end

  // ****************************************
  // Hub status bits
  // ****************************************
  logic global_overcurrent_flag_r;
  logic global_oc_nxt;
  logic overcurrent_change_flag_r;
  logic oc_chg_nxt;
  logic remote_wakeup_enable_r;
  logic wake_nxt;
  logic set_pwr_cmd;
  logic clr_pwr_cmd;

  assign global_oc_nxt = per_port_oc_r ? 1'b0 : oc_sync_r[1];
  assign oc_chg_nxt = (global_oc_nxt != global_overcurrent_flag_r) ? 1'b1 :
                      (wr_rh && hwdata[OC_CHANGE_BIT]) ? 1'b0 : overcurrent_change_flag_r;
  assign wake_nxt = (wr_rh && hwdata[WAKE_EN_BIT]) ? 1'b1 :
                    (wr_rh && hwdata[CLR_WAKE_BIT]) ? 1'b0 : remote_wakeup_enable_r;
  assign set_pwr_cmd = wr_rh && hwdata[SET_PWR_BIT];
  assign clr_pwr_cmd = wr_rh && hwdata[CLR_PWR_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      global_overcurrent_flag_r <= 1'b0;
      overcurrent_change_flag_r <= 1'b0;
      remote_wakeup_enable_r    <= 1'b0;
    end else begin
      global_overcurrent_flag_r <= global_oc_nxt;
      overcurrent_change_flag_r <= oc_chg_nxt;
      remote_wakeup_enable_r    <= wake_nxt;
    end
  end

  // ****************************************
  // Port power
  // ****************************************
  logic [NUM_PORTS:1] pwr_w;

  genvar gi;
  generate
    for (gi = 1; gi <= NUM_PORTS; gi = gi + 1) begin : g_port
      port_power_cell u_cell (
        .hclk          (hclk),
        .hresetn       (hresetn),
        .set_cmd       (set_pwr_cmd),
        .clr_cmd       (clr_pwr_cmd),
        .per_port_mode (per_port_switching_select_r),
        .mask_bit      (port_power_mask_field_r[gi]),
        .power_on      (pwr_w[gi])
      );
    end
  endgenerate

  // ****************************************
  // Suspend and resume
  // ****************************************
  hub_state_e state_r;
  hub_state_e state_nxt;
  logic       wake_event;

  // connect change wakes only when enabled
  assign wake_event = remote_wakeup_enable_r && cc_sync_r[1] && !cc_last_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RUNNING: begin
        if (suspend_req_r) begin
          state_nxt = ST_SUSPEND;
        end
      end
      ST_SUSPEND: begin
        if (wake_event) begin
          state_nxt = ST_RESUMING;
        end
      end
      ST_RESUMING: begin
        state_nxt = ST_RUNNING;
      end
      default: begin
        state_nxt = ST_RUNNING;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_RUNNING;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  logic [IRQ_BITS-1:0] irq_status_r;
  logic [IRQ_BITS-1:0] irq_enable_r;
  logic [IRQ_BITS-1:0] irq_event;
  logic                resume_evt;

  assign resume_evt = (state_r == ST_SUSPEND) && wake_event;
  assign irq_event  = {set_pwr_cmd || clr_pwr_cmd, resume_evt, oc_chg_nxt && !overcurrent_change_flag_r};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_r <= 3'h0;
      irq_enable_r <= 3'h0;
    end else begin
      irq_status_r <= irq_event | (irq_status_r & ~(wr_clr ? hwdata[IRQ_BITS-1:0] : 3'h0));
      if (wr_en) begin
        irq_enable_r <= hwdata[IRQ_BITS-1:0];
      end
    end
  end

  // ****************************************
  // Read data and outputs
  // ****************************************
  logic [31:0] rd_mux;

  // status low, changes high; bits 16 and 0 read zero
  assign rd_mux =
    (req_nxt.sel && !hwrite && haddr == RH_STATUS_ADDR) ?
      {14'h0, oc_chg_nxt, 1'b0, wake_nxt, 13'h0, global_oc_nxt, 1'b0} :
    (req_nxt.sel && !hwrite && haddr == PWR_CTRL_ADDR) ?
      {13'h0, port_power_mask_field_r, 14'h0, per_port_oc_r, per_port_switching_select_r} :
    (req_nxt.sel && !hwrite && haddr == PORT_STATE_ADDR) ? {29'h0, pwr_w, 1'b0} :
    (req_nxt.sel && !hwrite && haddr == WAKE_CTRL_ADDR) ? {29'h0, state_r} :
    (req_nxt.sel && !hwrite && haddr == IRQ_STATUS_ADDR) ? {29'h0, irq_status_r} :
    (req_nxt.sel && !hwrite && haddr == IRQ_ENABLE_ADDR) ? {29'h0, irq_enable_r} : 32'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata                <= RH_STATUS_RESET;
      hreadyout             <= 1'b1;
      hresp                 <= 1'b0;
      port_power_state      <= '0;
      resume_seen_interrupt <= 1'b0;
      suspended_state       <= 1'b0;
      resuming_state        <= 1'b0;
      irq                   <= 1'b0;
    end else begin
      hrdata                <= rd_mux;
      hreadyout             <= 1'b1;
      hresp                 <= 1'b0;
      port_power_state      <= pwr_w;
      resume_seen_interrupt <= irq_status_r[IRQ_RESUME];
      suspended_state       <= (state_r == ST_SUSPEND);
      resuming_state        <= (state_r == ST_RESUMING);
      irq                   <= |(irq_status_r & irq_enable_r);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_oc_toggle;
    global_oc_nxt != global_overcurrent_flag_r;
  endsequence

  a_oc_change_set: assert property (@(posedge hclk) disable iff (!hresetn)
    s_oc_toggle |=> overcurrent_change_flag_r)
    else $error("overcurrent change flag not set");
  a_oc_change_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    overcurrent_change_flag_r && !(wr_rh && hwdata[OC_CHANGE_BIT]) |=> overcurrent_change_flag_r)
    else $error("overcurrent change flag lost");
  a_wake_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_rh && hwdata[CLR_WAKE_BIT] && !hwdata[WAKE_EN_BIT] |=> !remote_wakeup_enable_r)
    else $error("wake enable not cleared");
  a_wake_set: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_rh && hwdata[WAKE_EN_BIT] |=> remote_wakeup_enable_r)
    else $error("wake enable not set");
  a_lp_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    req_nxt.sel && !hwrite && haddr == RH_STATUS_ADDR |=> !hrdata[SET_PWR_BIT] && !hrdata[CLR_PWR_BIT])
    else $error("local power bits not zero");
  a_global_on: assert property (@(posedge hclk) disable iff (!hresetn)
    set_pwr_cmd && !per_port_switching_select_r |=> ##1 (port_power_state == '1))
    else $error("global power on failed");
  a_global_off: assert property (@(posedge hclk) disable iff (!hresetn)
    clr_pwr_cmd && !set_pwr_cmd && !per_port_switching_select_r |=> ##1 (port_power_state == '0))
    else $error("global power off failed");
  a_masked_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    set_pwr_cmd && per_port_switching_select_r && port_power_mask_field_r[1]
      |=> $stable(pwr_w[1]))
    else $error("masked port changed");
  a_no_wake: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == ST_SUSPEND && !remote_wakeup_enable_r |=> state_r != ST_RESUMING)
    else $error("wake without enable");
  a_oc_perport: assert property (@(posedge hclk) disable iff (!hresetn)
    per_port_oc_r |=> !global_overcurrent_flag_r)
    else $error("global overcurrent not held");

endmodule

// >>> tb.sv
// Purpose: Self-checking bench for the root hub status register block
// Assumes: Zero-wait AHB-Lite slave; hready is looped back from hreadyout
// Notes:   Read words are checked by a monitor against a queue of expected words
`timescale 1ns/10ps
module tb;
  import rh_status_pkg::*;

  // ****************************************
  // Signals
  // ****************************************
  logic                 hclk                = 1'b0;
  logic                 hresetn             = 1'b0;
  logic                 hsel                = 1'b0;
  logic [11:0]          haddr               = 12'h000;
  logic [1:0]           htrans              = 2'b00;
  logic                 hwrite              = 1'b0;
  logic [31:0]          hwdata              = 32'h0000_0000;
  logic                 overcurrent_pin     = 1'b0;
  logic                 connect_change_flag = 1'b0;
  logic [31:0]          hrdata;
  logic                 hreadyout;
  logic                 hresp;
  logic [NUM_PORTS:1]   port_power_state;
  logic                 resume_seen_interrupt;
  logic                 suspended_state;
  logic                 resuming_state;
  logic                 irq;
  logic                 rd_phase            = 1'b0;
  logic [31:0]          exp_q[$];
  logic [31:0]          seed                = 32'h0000_187b;
  logic                 wake                = 1'b0;
  logic                 seen_resuming       = 1'b0;
  logic [31:0]          d;
  int                   failures            = 0;
  int                   n_tests             = 0;

  root_hub_status dut (
    .hclk                  (hclk),
    .hresetn               (hresetn),
    .hsel                  (hsel),
    .haddr                 (haddr),
    .htrans                (htrans),
    .hwrite                (hwrite),
    .hsize                 (3'b010),
    .hready                (hreadyout),
    .hwdata                (hwdata),
    .hrdata                (hrdata),
    .hreadyout             (hreadyout),
    .hresp                 (hresp),
    .overcurrent_pin       (overcurrent_pin),
    .connect_change_flag   (connect_change_flag),
    .port_power_state      (port_power_state),
    .resume_seen_interrupt (resume_seen_interrupt),
    .suspended_state       (suspended_state),
    .resuming_state        (resuming_state),
    .irq                   (irq)
  );

  always #10 hclk = ~hclk;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic wrap_up();
    $display("counts: %0d compared, %0d wrong", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] e);
    n_tests++;
    if (got !== e) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, e);
    end
  endtask

  // Waits for hready high at a rising edge, bounded
  task automatic wait_ready();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50) begin
      failures++;
      wrap_up();
    end
  endtask

  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] dat);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    wait_ready();
    htrans   <= 2'b00;
    hwdata   <= dat;
    rd_phase <= !wr;
    wait_ready();
    rd_phase <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] dat);
    xfer(1'b1, a, dat);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0000_0000);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // Read data taken at the edge that ends the data phase
  always @(posedge hclk) begin
    if (rd_phase && hreadyout === 1'b1) begin
      if (exp_q.size() == 0) begin
        failures++;
        $display("wrong value at %0t: got %h expected %h", $time, hrdata, 32'h0);
      end else begin
        cmp(hrdata, exp_q.pop_front());
      end
    end
  end

  // Catches the one-cycle resuming pulse
  always @(posedge hclk) begin
    seen_resuming <= seen_resuming | resuming_state;
  end

  initial begin
    repeat (20000) @(posedge hclk);
    failures++;
    wrap_up();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rd(RH_STATUS_ADDR, RH_STATUS_RESET);
    rd(PORT_STATE_ADDR, 32'h0000_0000);
    rd(IRQ_STATUS_ADDR, 32'h0000_0000);
    cmp({30'h0, hresp, hreadyout}, 32'h1);
    wr(12'h1f0, 32'hffff_ffff);
    rd(12'h1f0, 32'h0000_0000);
    $display("test reset done");
    wr(RH_STATUS_ADDR, 32'h0000_8000);
    rd(RH_STATUS_ADDR, 32'h0000_8000);
    wr(RH_STATUS_ADDR, 32'h0000_0000);
    rd(RH_STATUS_ADDR, 32'h0000_8000);
    wr(RH_STATUS_ADDR, 32'h8000_0000);
    rd(RH_STATUS_ADDR, 32'h0000_0000);
    $display("test wakeup enable done");
    overcurrent_pin <= 1'b1;
    idle(6);
    rd(RH_STATUS_ADDR, 32'h0002_0002);
    wr(RH_STATUS_ADDR, 32'h0000_0000);
    rd(RH_STATUS_ADDR, 32'h0002_0002);
    cmp({31'h0, irq}, 32'h0);
    wr(IRQ_ENABLE_ADDR, 32'h0000_0001);
    idle(2);
    cmp({31'h0, irq}, 32'h1);
    wr(RH_STATUS_ADDR, 32'h0002_0000);
    rd(RH_STATUS_ADDR, 32'h0000_0002);
    wr(IRQ_CLEAR_ADDR, 32'h0000_0001);
    idle(2);
    cmp({31'h0, irq}, 32'h0);
    overcurrent_pin <= 1'b0;
    idle(6);
    rd(RH_STATUS_ADDR, 32'h0002_0000);
    cmp({31'h0, irq}, 32'h1);
    wr(RH_STATUS_ADDR, 32'h0002_0000);
    wr(IRQ_CLEAR_ADDR, 32'h0000_0001);
    wr(IRQ_ENABLE_ADDR, 32'h0000_0000);
    $display("test overcurrent done");
    wr(PWR_CTRL_ADDR, 32'h0000_0000);
    wr(RH_STATUS_ADDR, 32'h0001_0000);
    rd(PORT_STATE_ADDR, 32'h0000_0006);
    cmp({30'h0, port_power_state}, 32'h3);
    rd(RH_STATUS_ADDR, 32'h0000_0000);
    wr(RH_STATUS_ADDR, 32'h0000_0001);
    rd(PORT_STATE_ADDR, 32'h0000_0000);
    wr(PWR_CTRL_ADDR, 32'h0004_0000);
    wr(RH_STATUS_ADDR, 32'h0001_0000);
    rd(PORT_STATE_ADDR, 32'h0000_0006);
    wr(RH_STATUS_ADDR, 32'h0000_0001);
    wr(PWR_CTRL_ADDR, 32'h0004_0001);
    wr(RH_STATUS_ADDR, 32'h0001_0000);
    rd(PORT_STATE_ADDR, 32'h0000_0002);
    wr(PWR_CTRL_ADDR, 32'h0000_0000);
    wr(RH_STATUS_ADDR, 32'h0001_0000);
    wr(PWR_CTRL_ADDR, 32'h0002_0001);
    wr(RH_STATUS_ADDR, 32'h0000_0001);
    rd(PORT_STATE_ADDR, 32'h0000_0002);
    cmp({30'h0, port_power_state}, 32'h1);
    wr(PWR_CTRL_ADDR, 32'h0000_0002);
    wr(IRQ_CLEAR_ADDR, 32'h0000_0004);
    overcurrent_pin <= 1'b1;
    idle(6);
    rd(RH_STATUS_ADDR, 32'h0000_0000);
    overcurrent_pin <= 1'b0;
    idle(6);
    wr(PWR_CTRL_ADDR, 32'h0000_0000);
    $display("test power done");
    wr(WAKE_CTRL_ADDR, 32'h0000_0001);
    idle(2);
    rd(WAKE_CTRL_ADDR, 32'h0000_0002);
    cmp({31'h0, suspended_state}, 32'h1);
    connect_change_flag <= 1'b1;
    idle(6);
    rd(WAKE_CTRL_ADDR, 32'h0000_0002);
    rd(IRQ_STATUS_ADDR, 32'h0000_0000);
    cmp({31'h0, seen_resuming}, 32'h0);
    connect_change_flag <= 1'b0;
    wr(RH_STATUS_ADDR, 32'h0000_8000);
    idle(4);
    connect_change_flag <= 1'b1;
    idle(6);
    rd(IRQ_STATUS_ADDR, 32'h0000_0002);
    rd(WAKE_CTRL_ADDR, 32'h0000_0001);
    cmp({31'h0, resume_seen_interrupt}, 32'h1);
    cmp({30'h0, suspended_state, seen_resuming}, 32'h1);
    cmp({31'h0, irq}, 32'h0);
    wr(IRQ_ENABLE_ADDR, 32'h0000_0002);
    idle(2);
    cmp({31'h0, irq}, 32'h1);
    wr(IRQ_CLEAR_ADDR, 32'h0000_0002);
    idle(2);
    cmp({31'h0, irq}, 32'h0);
    connect_change_flag <= 1'b0;
    wr(RH_STATUS_ADDR, 32'h8000_0000);
    $display("test resume done");
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      d = seed & 32'h8000_8000;
      wr(RH_STATUS_ADDR, d);
      wake = d[WAKE_EN_BIT] ? 1'b1 : (d[CLR_WAKE_BIT] ? 1'b0 : wake);
      rd(RH_STATUS_ADDR, {16'h0000, wake, 15'h0000});
      wr(12'h1f8, seed);
    end
    $display("test random done");
    wrap_up();
  end
endmodule
